// >>> design/cvr_control.sv
// cvr_control: control and status logic around one analog comparator
// and its programmable voltage reference.
// assumes the analog comparator, reference ladder and pad drivers sit
// outside; their raw result arrives asynchronously.
//
// How it works
// - result high when positive above negative
// - invert bit flips the reported result
// - mode field picks one of eight modes
// - direction register still steers comparator pins
// - result bit readable, writes ignored
// - output modes drive pin unsynchronised
// - pin direction bit gates output driver
// - analog pins read back as zero
// - four modes use internal reference
// - thirty-two reference levels over two ranges
// - low range tap is code over 24
// - high range tap quarter plus code/32
// - comparator and reference keep running asleep
// - mode 111 and enable bit power off
// - change while asleep wakes the device
// - waking leaves both control registers alone
// - reset loads mode 000, all off
// - range bit is bit 5, 1 low
// - reference bits 6 and 4 read zero
// - bits 3..0 hold the level code
// - control register field layout fixed
// - any output change sets the flag
// - control register access ends the mismatch
`timescale 1ns/1ps
`default_nettype none
module cvr_control #(
  parameter int PINS = cvr_pkg::PORT_PINS
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  // register port
  input  wire logic [7:0]      regAddr,
  input  wire logic [7:0]      regWdata,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output logic      [7:0]      regRdata,
  // analog comparator and reference ladder
  input  wire logic            cmpRaw,
  output logic                 cmpEnable,
  output logic                 inputSwitch,
  output logic                 refToInput,
  output logic                 refEnable,
  output logic                 refRangeLow,
  output logic      [3:0]      refLevel,
  output logic      [6:0]      refTapNum,
  // port pins
  input  wire logic [PINS-1:0] padIn,
  output logic      [PINS-1:0] padOe,
  output logic      [PINS-1:0] analogMask,
  output logic                 compOutPin,
  output logic                 compOutOe,
  // power management
  input  wire logic            sleepActive,
  output logic                 changeFlag,
  output logic                 wakeReq
);

  // control state
  logic            invert_q;
  logic            inSwitch_q;
  logic [2:0]      mode_q;
  logic            refOn_q;
  logic            rangeLow_q;
  logic [3:0]      code_q;
  logic [PINS-1:0] dir_q;
  logic            flag_q;
  logic            copy_q;
  logic            wake_q;

  logic [PINS:0]   syncAll;
  logic            syncRaw;
  logic [PINS-1:0] padSync;
  logic            cmpResult;
  logic            mismatch;
  logic [4:0]      modeInfo;
  logic            outMode;
  logic [PINS-1:0] pinsRead;
  logic            ctrlAccess;
  logic [7:0]      ctrlRead;
  logic [7:0]      vrefRead;

  function automatic logic [4:0] mode_decode(input logic [2:0] m);
    mode_decode = cvr_pkg::MODE_TABLE[5*m +: 5];
  endfunction : mode_decode

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  // one synchroniser bundle keeps the raw result and pads in step
  cvr_sync #(
    .WIDTH (PINS + 1)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  ({cmpRaw, padIn}),
    .syncOut  (syncAll)
  );
  assign syncRaw = syncAll[PINS];
  assign padSync = syncAll[PINS-1:0];

  assign cmpResult = syncRaw ^ invert_q;
  assign mismatch  = cmpResult != copy_q;
  assign ctrlAccess = (regWr | regRd) && hit(regAddr, cvr_pkg::CTRL_ADDR);

  // mode decode
  assign modeInfo    = mode_decode(mode_q);
  assign outMode     = modeInfo[4];
  assign refToInput  = modeInfo[3];
  assign cmpEnable   = (mode_q != cvr_pkg::MODE_OFF)
                    && (mode_q != cvr_pkg::MODE_RESETM);
  assign inputSwitch = inSwitch_q;
  assign refEnable   = refOn_q;
  assign refRangeLow = rangeLow_q;
  assign refLevel    = code_q;

  // tap numerator over REF_DEN; the ladder turns it into a voltage
  always_comb begin
    if (rangeLow_q) begin
      refTapNum = 7'(code_q * cvr_pkg::LOW_STEP);
    end else begin
      refTapNum = cvr_pkg::HIGH_BASE + 7'(code_q * cvr_pkg::HIGH_STEP);
    end
  end

  // pins: analog mask covers the three comparator pins only
  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      if (i < 3) begin : g_cmp
        assign analogMask[i] = modeInfo[i];
      end else begin : g_dig
        assign analogMask[i] = 1'b0;
      end
      assign pinsRead[i] = padSync[i] & ~analogMask[i];
      if (i == cvr_pkg::OUT_PIN) begin : g_out
        assign padOe[i] = ~dir_q[i] & ~outMode;
      end else begin : g_norm
        assign padOe[i] = ~dir_q[i];
      end
    end
  endgenerate

  // the pin takes the raw comparator, so its timing is analog, not clocked
  assign compOutPin = (cmpRaw ^ invert_q) & outMode;
  assign compOutOe  = outMode & ~dir_q[cvr_pkg::OUT_PIN];

  // comparator_control: only reset or a write changes it, sleep does not
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      invert_q   <= 1'b0;
      inSwitch_q <= 1'b0;
      mode_q     <= cvr_pkg::MODE_RESET;
    end else if (regWr && hit(regAddr, cvr_pkg::CTRL_ADDR)) begin
      invert_q   <= regWdata[cvr_pkg::CTRL_INV_BIT];
      inSwitch_q <= regWdata[cvr_pkg::CTRL_CIS_BIT];
      mode_q     <= regWdata[cvr_pkg::CTRL_MODE_LSB +: 3];
    end
  end

  // voltage_reference_control
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      refOn_q    <= 1'b0;
      rangeLow_q <= 1'b0;
      code_q     <= cvr_pkg::CODE_RESET;
    end else if (regWr && hit(regAddr, cvr_pkg::VREF_ADDR)) begin
      refOn_q    <= regWdata[cvr_pkg::VREF_ON_BIT];
      rangeLow_q <= regWdata[cvr_pkg::VREF_RANGE_BIT];
      code_q     <= regWdata[cvr_pkg::VREF_CODE_LSB +: 4];
    end
  end

  // port direction
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dir_q <= cvr_pkg::DIR_RESET;
    end else if (regWr && hit(regAddr, cvr_pkg::DIR_ADDR)) begin
      dir_q <= regWdata[PINS-1:0];
    end
  end

  // copy of the result taken at every control register access
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      copy_q <= 1'b0;
    end else if (ctrlAccess) begin
      copy_q <= cmpResult;
    end
  end

  // change flag: a live mismatch wins over a software clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else if (mismatch) begin
      flag_q <= 1'b1;
    end else if (regWr && hit(regAddr, cvr_pkg::FLAG_ADDR)) begin
      flag_q <= regWdata[cvr_pkg::FLAG_BIT];
    end
  end
  assign changeFlag = flag_q;

  // no clock gating here, so both units keep running through sleep
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleepActive & cmpEnable & flag_q;
    end
  end
  assign wakeReq = wake_q;

  // read data
  always_comb begin
    ctrlRead = 8'h00;
    ctrlRead[cvr_pkg::CTRL_RESULT_BIT] = cmpResult;
    ctrlRead[cvr_pkg::CTRL_INV_BIT]    = invert_q;
    ctrlRead[cvr_pkg::CTRL_CIS_BIT]    = inSwitch_q;
    ctrlRead[cvr_pkg::CTRL_MODE_LSB +: 3] = mode_q;
    vrefRead = 8'h00;
    vrefRead[cvr_pkg::VREF_ON_BIT]    = refOn_q;
    vrefRead[cvr_pkg::VREF_RANGE_BIT] = rangeLow_q;
    vrefRead[cvr_pkg::VREF_CODE_LSB +: 4] = code_q;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (hit(regAddr, cvr_pkg::CTRL_ADDR)) begin
        regRdata <= ctrlRead;
      end else if (hit(regAddr, cvr_pkg::VREF_ADDR)) begin
        regRdata <= vrefRead;
      end else if (hit(regAddr, cvr_pkg::DIR_ADDR)) begin
        regRdata <= 8'(dir_q);
      end else if (hit(regAddr, cvr_pkg::PINS_ADDR)) begin
        regRdata <= 8'(pinsRead);
      end else if (hit(regAddr, cvr_pkg::FLAG_ADDR)) begin
        regRdata <= 8'(flag_q) << cvr_pkg::FLAG_BIT;
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

  // checks
  result_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    regRd && regAddr == cvr_pkg::CTRL_ADDR
    |=> regRdata[6] == ($past(syncRaw) ^ $past(invert_q)))
    else $error("result bit does not follow input and polarity");

  result_ro_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWr && regAddr == cvr_pkg::CTRL_ADDR
    |=> mode_q == $past(regWdata[2:0]) && invert_q == $past(regWdata[4])
        && cmpResult == (syncRaw ^ invert_q))
    else $error("control write stored wrong fields");

  out_pin_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    compOutOe == (modeInfo[4] && !dir_q[2]) && (!outMode || !padOe[2]))
    else $error("output pin enable wrong");

  pins_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    regRd && regAddr == cvr_pkg::PINS_ADDR
    |=> (regRdata[2:0] & $past(analogMask[2:0])) == 3'h0)
    else $error("analog pin read nonzero");

  ref_tap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    refTapNum == (rangeLow_q ? 7'(4 * code_q) : 7'(24 + 3 * code_q)))
    else $error("reference tap wrong");

  vref_unimpl_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    regRd && regAddr == cvr_pkg::VREF_ADDR
    |=> regRdata[6] == 1'b0 && regRdata[4] == 1'b0 && regRdata[5] == $past(rangeLow_q))
    else $error("reference unimplemented bits nonzero");

  reset_state_a: assert property (@(posedge core_clk)
    !reset_n |=> mode_q == 3'h0 && !refOn_q && !cmpEnable && analogMask[2:0] == 3'h7)
    else $error("reset state wrong");

  flag_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mismatch |=> flag_q)
    else $error("change did not set flag");

  access_ends_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrlAccess ##1 !ctrlAccess && $stable(cmpResult) |-> !mismatch)
    else $error("control access did not end mismatch");

  off_mode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode_q == 3'h7 |-> !cmpEnable && !compOutOe)
    else $error("off mode leaves comparator on");

  wake_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sleepActive && cmpEnable && flag_q |=> wakeReq)
    else $error("no wake on change in sleep");

  hold_regs_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !regWr |=> $stable(mode_q) && $stable(refOn_q) && $stable(code_q))
    else $error("control changed without a write");

  flag_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWr && regAddr == cvr_pkg::FLAG_ADDR && !mismatch
    |=> flag_q == $past(regWdata[cvr_pkg::FLAG_BIT]))
    else $error("software flag write not applied");

  out_modes_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    outMode == (mode_q == 3'h1 || mode_q == 3'h3 || mode_q == 3'h5))
    else $error("pin output in wrong mode");

  ref_modes_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    refToInput == (mode_q >= 3'h3 && mode_q <= 3'h6))
    else $error("reference routed in wrong mode");

  sleep_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sleepActive && !regWr |=> cmpEnable == $past(cmpEnable) && refEnable == $past(refEnable))
    else $error("sleep switched a unit off");

  // holds only while the raw level is quiet during reset, as the model gives
  result_sync_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmpResult == ($past(cmpRaw, 2) ^ invert_q))
    else $error("result not two flops behind raw");

  change_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    mismatch ##1 flag_q ##[1:20] ctrlAccess);
  outmode_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    compOutOe && compOutPin);
  wake_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    sleepActive ##[1:40] wakeReq);
  flagclr_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    flag_q ##1 !flag_q);

endmodule : cvr_control
`default_nettype wire

// >>> design/cvr_pkg.sv
// cvr_pkg: register map, field positions, reset values and mode codes
// for the comparator and voltage reference control block.
// assumes an 8-bit register port with byte-wide registers at fixed addresses.
package cvr_pkg;

  // register addresses on the plain register port
  localparam logic [7:0] CTRL_ADDR  = 8'h19;
  localparam logic [7:0] VREF_ADDR  = 8'h99;
  localparam logic [7:0] DIR_ADDR   = 8'h85;
  localparam logic [7:0] PINS_ADDR  = 8'h05;
  localparam logic [7:0] FLAG_ADDR  = 8'h0C;

  // comparator_control fields
  localparam int CTRL_RESULT_BIT = 6;
  localparam int CTRL_INV_BIT    = 4;
  localparam int CTRL_CIS_BIT    = 3;
  localparam int CTRL_MODE_LSB   = 0;

  // voltage_reference_control fields
  localparam int VREF_ON_BIT    = 7;
  localparam int VREF_RANGE_BIT = 5;
  localparam int VREF_CODE_LSB  = 0;

  // change flag position in the flag register
  localparam int FLAG_BIT = 3;

  // reset values
  localparam logic [2:0] MODE_RESET  = 3'h0;
  localparam logic [3:0] CODE_RESET  = 4'h0;
  localparam logic [5:0] DIR_RESET   = 6'h3F;

  // mode codes
  localparam logic [2:0] MODE_RESETM = 3'h0;
  localparam logic [2:0] MODE_OFF    = 3'h7;

  // per-mode pin usage: {output mode, internal reference, analog mask[2:0]}
  localparam logic [39:0] MODE_TABLE = {
    5'h00,  // 111 off, comparator pins digital
    5'h0B,  // 110 internal reference, switched input
    5'h19,  // 101 internal reference, output on pin 2
    5'h09,  // 100 internal reference, no output
    5'h1B,  // 011 internal reference, output on pin 2
    5'h03,  // 010 two pins, switched input
    5'h13,  // 001 two pins, output on pin 2
    5'h07   // 000 reset mode, all analog
  };

  // reference tap expressed as a fraction of supply over a common denominator
  localparam int         REF_DEN      = 96;
  localparam int         LOW_STEP     = REF_DEN / 24;
  localparam int         HIGH_STEP    = REF_DEN / 32;
  localparam logic [6:0] HIGH_BASE    = 7'(REF_DEN / 4);

  localparam int PORT_PINS = 6;
  localparam int OUT_PIN   = 2;

endpackage : cvr_pkg

// >>> design/cvr_sync.sv
// cvr_sync: two-flop synchroniser for a bundle of asynchronous levels.
// assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ps
`default_nettype none
module cvr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : cvr_sync
`default_nettype wire

// >>> test/cvr_analog_model.sv
// cvr_analog_model: behavioural comparator front end and reference ladder
// seen from the control block; levels are numerators over 96 of supply.
// assumes the bench sets the pin levels and the block drives the controls.
`timescale 1ns/1ps
`default_nettype none
module cvr_analog_model (
  // pin levels from the bench
  input  wire logic [6:0] posLevel,
  input  wire logic [6:0] negLevel,
  // controls from the block
  input  wire logic [6:0] refTapNum,
  input  wire logic       refToInput,
  input  wire logic       refEnable,
  input  wire logic       cmpEnable,
  // raw result, asynchronous
  output logic            cmpRaw
);
  logic [6:0] negEff;
  // a powered-down ladder cannot stand in for the pin
  assign negEff = (refToInput && refEnable) ? refTapNum : negLevel;
  // an unpowered comparator gives a steady low
  assign cmpRaw = cmpEnable && (posLevel > negEff);
endmodule : cvr_analog_model
`default_nettype wire

// >>> test/comparator_vref_control_tb_top.sv
// comparator_vref_control_tb_top: register-level bench for cvr_control.
// assumes the analog model closes the loop from reference tap to raw result.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module comparator_vref_control_tb_top;
  logic       core_clk    = 1'b0;
  logic       reset_n     = 1'b0;
  logic [7:0] regAddr     = 8'h00;
  logic [7:0] regWdata    = 8'h00;
  logic       regWr       = 1'b0;
  logic       regRd       = 1'b0;
  logic [5:0] padIn       = 6'h00;
  logic       sleepActive = 1'b0;
  logic [6:0] posLvl      = 7'h00;
  logic [6:0] negLvl      = 7'h00;
  wire  [7:0] regRdata;
  wire  [6:0] refTapNum;
  wire  [5:0] padOe;
  wire  [5:0] analogMask;
  wire  [3:0] refLevel;
  wire        cmpRaw, cmpEnable, inputSwitch, refToInput, refEnable, refRangeLow;
  wire        compOutPin, compOutOe, changeFlag, wakeReq;
  int         bad_count   = 0;
  int         checks_done = 0;
  logic [7:0] rv;
  logic [2:0] maskTab [8] = '{3'h7, 3'h3, 3'h3, 3'h3, 3'h1, 3'h1, 3'h3, 3'h0};

  always #2 core_clk = ~core_clk;

  cvr_control u_cvr_control (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .cmpRaw(cmpRaw), .cmpEnable(cmpEnable), .inputSwitch(inputSwitch),
    .refToInput(refToInput), .refEnable(refEnable), .refRangeLow(refRangeLow),
    .refLevel(refLevel), .refTapNum(refTapNum), .padIn(padIn), .padOe(padOe),
    .analogMask(analogMask), .compOutPin(compOutPin), .compOutOe(compOutOe),
    .sleepActive(sleepActive), .changeFlag(changeFlag), .wakeReq(wakeReq));

  cvr_analog_model u_cvr_analog_model (.posLevel(posLvl), .negLevel(negLvl),
    .refTapNum(refTapNum), .refToInput(refToInput), .refEnable(refEnable),
    .cmpEnable(cmpEnable), .cmpRaw(cmpRaw));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // outputs are looked at 1 ns after the edge so the write has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  initial begin
    repeat (50000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end

  initial begin
    settle(20);
    `CHK("rst regRdata", 8'h00, regRdata)
    `CHK("rst mask", 6'h07, analogMask)
    `CHK("rst cmpEnable", 1'b0, cmpEnable)
    `CHK("rst refEnable", 1'b0, refEnable)
    `CHK("rst padOe", 6'h00, padOe)
    @(posedge core_clk);
    reset_n <= 1'b1;
    rd(cvr_pkg::CTRL_ADDR, rv);
    `CHK("ctrl reset", 8'h00, rv)
    rd(cvr_pkg::VREF_ADDR, rv);
    `CHK("vref reset", 8'h00, rv)
    rd(cvr_pkg::DIR_ADDR, rv);
    `CHK("dir reset", 8'h3F, rv)
    wr(8'h33, 8'hFF);
    rd(8'h33, rv);
    `CHK("unmapped", 8'h00, rv)
    // every level in both ranges
    for (int c = 0; c < 16; c++) begin
      wr(cvr_pkg::VREF_ADDR, 8'hA0 | 8'(c));
      `CHK("tap low", 7'(4 * c), refTapNum)
      wr(cvr_pkg::VREF_ADDR, 8'h80 | 8'(c));
      `CHK("tap high", 7'(24 + 3 * c), refTapNum)
      `CHK("level", 4'(c), refLevel)
    end
    wr(cvr_pkg::VREF_ADDR, 8'h2F);
    `CHK("ref off", 1'b0, refEnable)
    wr(cvr_pkg::VREF_ADDR, 8'hFF);
    rd(cvr_pkg::VREF_ADDR, rv);
    `CHK("vref bits", 8'hAF, rv)
    `CHK("range low", 1'b1, refRangeLow)
    wr(cvr_pkg::DIR_ADDR, 8'h00);
    // every mode with all pins set to drive
    for (int m = 0; m < 8; m++) begin
      wr(cvr_pkg::CTRL_ADDR, 8'h08 | 8'(m));
      `CHK("mask", {3'h0, maskTab[m]}, analogMask)
      `CHK("enable", 1'(m != 0 && m != 7), cmpEnable)
      `CHK("ref mode", 1'(m >= 3 && m <= 6), refToInput)
      `CHK("out oe", 1'(m == 1 || m == 3 || m == 5), compOutOe)
      `CHK("padOe", (m == 1 || m == 3 || m == 5) ? 6'h3B : 6'h3F, padOe)
      `CHK("switch", 1'b1, inputSwitch)
    end
    wr(cvr_pkg::DIR_ADDR, 8'h04);
    wr(cvr_pkg::CTRL_ADDR, 8'h01);
    `CHK("oe off", 1'b0, compOutOe)
    wr(cvr_pkg::DIR_ADDR, 8'h00);
    `CHK("oe on", 1'b1, compOutOe)
    posLvl <= 7'd50;
    negLvl <= 7'd10;
    #1;
    `CHK("pin raw", 1'b1, compOutPin)
    settle(3);
    rd(cvr_pkg::CTRL_ADDR, rv);
    `CHK("ctrl result", 8'h41, rv)
    wr(cvr_pkg::CTRL_ADDR, 8'hD1);
    `CHK("pin inv", 1'b0, compOutPin)
    settle(3);
    rd(cvr_pkg::CTRL_ADDR, rv);
    `CHK("ctrl inv", 8'h11, rv)
    posLvl <= 7'd5;
    #1;
    `CHK("pin inv low", 1'b1, compOutPin)
    settle(3);
    rd(cvr_pkg::CTRL_ADDR, rv);
    `CHK("ctrl inv low", 8'h51, rv)
    // reference against the positive pin, tap 20 of 96
    wr(cvr_pkg::VREF_ADDR, 8'hA5);
    wr(cvr_pkg::CTRL_ADDR, 8'h03);
    posLvl <= 7'd21;
    #1;
    `CHK("ref above", 1'b1, compOutPin)
    posLvl <= 7'd19;
    #1;
    `CHK("ref below", 1'b0, compOutPin)
    @(posedge core_clk);
    padIn <= 6'h3F;
    wr(cvr_pkg::CTRL_ADDR, 8'h00);
    settle(3);
    rd(cvr_pkg::PINS_ADDR, rv);
    `CHK("pins analog", 8'h38, rv)
    wr(cvr_pkg::CTRL_ADDR, 8'h07);
    rd(cvr_pkg::PINS_ADDR, rv);
    `CHK("pins digital", 8'h3F, rv)
    // change flag and mismatch
    wr(cvr_pkg::CTRL_ADDR, 8'h01);
    settle(3);
    rd(cvr_pkg::CTRL_ADDR, rv);
    wr(cvr_pkg::FLAG_ADDR, 8'h00);
    `CHK("flag clear", 1'b0, changeFlag)
    // drop below the negative pin so the result really changes
    posLvl <= 7'd5;
    settle(5);
    `CHK("flag set", 1'b1, changeFlag)
    wr(cvr_pkg::FLAG_ADDR, 8'h00);
    `CHK("flag held", 1'b1, changeFlag)
    rd(cvr_pkg::CTRL_ADDR, rv);
    wr(cvr_pkg::FLAG_ADDR, 8'h00);
    `CHK("flag freed", 1'b0, changeFlag)
    wr(cvr_pkg::FLAG_ADDR, 8'h08);
    rd(cvr_pkg::FLAG_ADDR, rv);
    `CHK("flag soft", 8'h08, rv)
    @(posedge core_clk);
    sleepActive <= 1'b1;
    settle(2);
    `CHK("wake", 1'b1, wakeReq)
    `CHK("asleep on", 1'b1, cmpEnable)
    @(posedge core_clk);
    sleepActive <= 1'b0;
    settle(1);
    rd(cvr_pkg::CTRL_ADDR, rv);
    `CHK("ctrl kept", 8'h01, rv)
    rd(cvr_pkg::VREF_ADDR, rv);
    `CHK("vref kept", 8'hA5, rv)
    finish_test();
  end
endmodule : comparator_vref_control_tb_top
`default_nettype wire
